// [dtp_pwm.sv]
// Purpose: Three-channel pulse-width modulator on two 8-bit period timers.
// Assumes: sys_clk is the oscillator; the Q-phase counter makes instruction cycles.
// Notes: Duty registers are double buffered; reads show the active latch.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - External falling edge advances selected timer
// - External clock pin passes two-stage synchroniser
// - Channel one always uses timer one
// - Channel two timebase chosen by its select bit
// - Channel three timebase chosen by its select bit
// - No sixteen-bit joining while channels used
// - Duty is high byte plus two low bits
// - High time is duty oscillator periods
// - Zero duty keeps output low
// - Duty high equal period gives short low
// - Full high only when duty exceeds period
// - Writes to master, copied at period start
// - Duty reads return active slave latches
// - Match then advance clears timer, sets flag
// - Timer flags cleared only by software
// - Internal source advances once per instruction
// - Stopped timer neither counts nor flags, except timer two carried in wide mode
// - Timers independent while wide mode clear
module dtp_pwm (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [dtp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dtp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dtp_pkg::DATA_W-1:0] reg_rdata_q,
	input wire logic ext_timer_clock_pin,
	output logic channel_one,
	output logic channel_two,
	output logic channel_three,
	output logic timer1_flag,
	output logic timer2_flag
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [dtp_pkg::PHASE_W-1:0] phase_q;
	logic instr_tick;
	logic ext_meta_q;
	logic ext_sync_q;
	logic ext_prev_q;
	logic ext_fall;
	logic [dtp_pkg::DATA_W-1:0] ctrl_q;
	logic [dtp_pkg::DATA_W-1:0] period_one_q;
	logic [dtp_pkg::DATA_W-1:0] period_two_q;
	logic [dtp_pkg::DATA_W-1:0] timer_one;
	logic [dtp_pkg::DATA_W-1:0] timer_two;
	logic [dtp_pkg::NUM_CH-1:0] ch_enable;
	logic any_channel;
	logic wide_active;
	logic match_wide;
	logic src_one;
	logic src_two;
	logic inc_one;
	logic inc_two;
	logic wrap_one;
	logic wrap_two;
	logic roll_one;
	logic roll_two;
	logic load_one;
	logic load_two;
	logic flag_clr_wr;
	logic timer1_flag_d;
	logic timer2_flag_d;
	logic [dtp_pkg::DATA_W-1:0] master_high_q [dtp_pkg::NUM_CH];
	logic [2:0] master_low_q [dtp_pkg::NUM_CH];
	logic [dtp_pkg::DUTY_W-1:0] master_duty [dtp_pkg::NUM_CH];
	logic [dtp_pkg::DUTY_W-1:0] slave_duty [dtp_pkg::NUM_CH];
	logic [dtp_pkg::NUM_CH-1:0] ch_tb_two;
	logic [dtp_pkg::NUM_CH-1:0] ch_start;
	logic [dtp_pkg::NUM_CH-1:0] ch_pwm;
	logic [dtp_pkg::DATA_W-1:0] ch_count [dtp_pkg::NUM_CH];
	logic [dtp_pkg::DATA_W-1:0] rdata_d;

	// ----------------------------------------------------------------
	// Q-phase counter and instruction tick
	// ----------------------------------------------------------------

	// Free-running Q1..Q4 phase, one oscillator period each
	// Starts at zero, so the first tick falls on the fourth edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// One tick per four oscillator periods
	assign instr_tick = (phase_q == dtp_pkg::PHASE_LAST);

	// ----------------------------------------------------------------
	// External timer clock input
	// ----------------------------------------------------------------

	// Two-stage synchroniser; idle level high so reset gives no edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_meta_q <= 1'b1;
			ext_sync_q <= 1'b1;
		end else begin
			ext_meta_q <= ext_timer_clock_pin;
			ext_sync_q <= ext_meta_q;
		end
	end

	// Edge detector reads only the settled stage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ext_prev_q <= 1'b1;
		end else begin
			ext_prev_q <= ext_sync_q;
		end
	end

	// Falling edge lags the pin by the synchroniser depth
	// Limitation: pin levels shorter than one clock can be missed
	assign ext_fall = ext_prev_q & ~ext_sync_q;

	// ----------------------------------------------------------------
	// Control and period registers
	// ----------------------------------------------------------------

	// Run, clock source, wide mode and channel enables
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= dtp_pkg::CTRL_RST;
		end else if (reg_wr && reg_addr == dtp_pkg::REG_CTRL) begin
			ctrl_q <= reg_wdata;
		end
	end

	// Period registers take effect on the next compare
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			period_one_q <= dtp_pkg::PERIOD_RST;
			period_two_q <= dtp_pkg::PERIOD_RST;
		end else if (reg_wr && reg_addr == dtp_pkg::REG_PERIOD_ONE) begin
			period_one_q <= reg_wdata;
		end else if (reg_wr && reg_addr == dtp_pkg::REG_PERIOD_TWO) begin
			period_two_q <= reg_wdata;
		end
	end

	// Channel enables sit above the run, source and wide bits
	assign ch_enable = ctrl_q[dtp_pkg::CTRL_EN_LSB +: dtp_pkg::NUM_CH];
	assign any_channel = |ch_enable;
	// Joining is refused while any channel runs
	assign wide_active = ctrl_q[dtp_pkg::CTRL_WIDE] & ~any_channel;

	// ----------------------------------------------------------------
	// Timer advance and wrap
	// ----------------------------------------------------------------

	// Clock source per timer: instruction tick or external falling edge
	assign src_one = ctrl_q[dtp_pkg::CTRL_CS1] ? ext_fall : instr_tick;
	assign src_two = ctrl_q[dtp_pkg::CTRL_CS2] ? ext_fall : instr_tick;

	// Sixteen-bit match across both timers, only used in wide mode
	assign match_wide = ({timer_two, timer_one} == {period_two_q, period_one_q});

	// A stopped timer one never advances, so it can never raise its flag
	assign inc_one = ctrl_q[dtp_pkg::CTRL_RUN1] & src_one;

	// Wide mode carries timer one into timer two
	always_comb begin
		if (wide_active) begin
			wrap_one = match_wide;
			wrap_two = match_wide;
			inc_two = inc_one & ((timer_one == dtp_pkg::TIMER_MAX) | match_wide);
		end else begin
			wrap_one = (timer_one == period_one_q);
			wrap_two = (timer_two == period_two_q);
			inc_two = ctrl_q[dtp_pkg::CTRL_RUN2] & src_two;
		end
	end

	// Rollover is the advance that folds a timer back to zero
	assign roll_one = inc_one & wrap_one;
	assign roll_two = inc_two & wrap_two & ~wide_active;

	// Software loads go straight into the counters
	assign load_one = reg_wr && (reg_addr == dtp_pkg::REG_TIMER_ONE);
	assign load_two = reg_wr && (reg_addr == dtp_pkg::REG_TIMER_TWO);

	// ----------------------------------------------------------------
	// Timers
	// ----------------------------------------------------------------
	// Both timers take their load value from the write data
	dtp_timer u_timer_one (
		.sys_clk(sys_clk),
		.rst(rst),
		.inc(inc_one),
		.wrap(wrap_one),
		.load(load_one),
		.load_data(reg_wdata),
		.count_q(timer_one)
	);

	dtp_timer u_timer_two (
		.sys_clk(sys_clk),
		.rst(rst),
		.inc(inc_two),
		.wrap(wrap_two),
		.load(load_two),
		.load_data(reg_wdata),
		.count_q(timer_two)
	);

	// ----------------------------------------------------------------
	// Timer flags
	// ----------------------------------------------------------------

	// Write one to clear; a rollover in the same cycle wins
	assign flag_clr_wr = reg_wr && (reg_addr == dtp_pkg::REG_FLAGS);
	assign timer1_flag_d = roll_one |
		(timer1_flag & ~(flag_clr_wr & reg_wdata[dtp_pkg::FLAG_T1]));
	assign timer2_flag_d = roll_two |
		(timer2_flag & ~(flag_clr_wr & reg_wdata[dtp_pkg::FLAG_T2]));

	// Hardware only ever sets these
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			timer1_flag <= 1'b0;
			timer2_flag <= 1'b0;
		end else begin
			timer1_flag <= timer1_flag_d;
			timer2_flag <= timer2_flag_d;
		end
	end

	// ----------------------------------------------------------------
	// Duty master latches and channels
	// ----------------------------------------------------------------
	// One master latch pair and one channel per entry
	genvar gi;
	generate
		for (gi = 0; gi < dtp_pkg::NUM_CH; gi++) begin : g_ch
			localparam logic [dtp_pkg::ADDR_W-1:0] ADDR_HIGH =
				dtp_pkg::REG_DUTY_BASE + dtp_pkg::ADDR_W'(2 * gi);
			localparam logic [dtp_pkg::ADDR_W-1:0] ADDR_LOW =
				dtp_pkg::REG_DUTY_BASE + dtp_pkg::ADDR_W'(2 * gi + 1);

			// Software writes land in the master only
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					master_high_q[gi] <= dtp_pkg::DUTY_RST[9:2];
					master_low_q[gi] <= 3'h0;
				end else if (reg_wr && reg_addr == ADDR_HIGH) begin
					master_high_q[gi] <= reg_wdata;
				end else if (reg_wr && reg_addr == ADDR_LOW) begin
					master_low_q[gi] <= reg_wdata[7:5];
				end
			end

			// High byte on top, low-register bits 7:6 below
			assign master_duty[gi] = {master_high_q[gi], master_low_q[gi][2:1]};

			// Timebase select acts at once, it is not double buffered
			if (gi == 0) begin : g_fixed
				assign ch_tb_two[gi] = 1'b0;
			end else begin : g_sel
				assign ch_tb_two[gi] = master_low_q[gi][0];
			end

			// Compare count and period start follow the chosen timebase
			assign ch_count[gi] = ch_tb_two[gi] ? timer_two : timer_one;
			assign ch_start[gi] = ch_tb_two[gi] ? roll_two : roll_one;

			dtp_channel u_channel (
				.sys_clk(sys_clk),
				.rst(rst),
				.enable(ch_enable[gi]),
				.period_start(ch_start[gi]),
				.timer_count(ch_count[gi]),
				.phase(phase_q),
				.master_duty(master_duty[gi]),
				.slave_duty_q(slave_duty[gi]),
				.pwm_q(ch_pwm[gi])
			);
		end
	endgenerate

	// Channel flops drive the pins directly
	assign channel_one = ch_pwm[0];
	assign channel_two = ch_pwm[1];
	assign channel_three = ch_pwm[2];

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------

	// Duty reads show the slave latch; unmapped indices read zero
	always_comb begin
		rdata_d = '0;
		if (reg_addr == dtp_pkg::REG_CTRL) begin
			rdata_d = ctrl_q;
		end else if (reg_addr == dtp_pkg::REG_FLAGS) begin
			rdata_d[dtp_pkg::FLAG_T1] = timer1_flag;
			rdata_d[dtp_pkg::FLAG_T2] = timer2_flag;
		end else if (reg_addr == dtp_pkg::REG_TIMER_ONE) begin
			rdata_d = timer_one;
		end else if (reg_addr == dtp_pkg::REG_TIMER_TWO) begin
			rdata_d = timer_two;
		end else if (reg_addr == dtp_pkg::REG_PERIOD_ONE) begin
			rdata_d = period_one_q;
		end else if (reg_addr == dtp_pkg::REG_PERIOD_TWO) begin
			rdata_d = period_two_q;
		end else begin
			for (int i = 0; i < dtp_pkg::NUM_CH; i++) begin
				if (reg_addr == dtp_pkg::REG_DUTY_BASE + dtp_pkg::ADDR_W'(2 * i)) begin
					rdata_d = slave_duty[i][9:2];
				end else if (reg_addr ==
					dtp_pkg::REG_DUTY_BASE + dtp_pkg::ADDR_W'(2 * i + 1)) begin
					rdata_d[7:6] = slave_duty[i][1:0];
					rdata_d[dtp_pkg::TB_SEL_BIT] = master_low_q[i][0];
				end
			end
		end
	end

	// Read data stands only in the cycle after the strobe
	// Zero outside the answer keeps stale data off the bus
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end else begin
			reg_rdata_q <= '0;
		end
	end

endmodule : dtp_pwm

// [dtp_pkg.sv]
// Purpose: Shared constants for the dual timebase pulse-width modulator.
// Assumes: 8-bit register port, 4-bit word index, 100 MHz oscillator clock.
// Notes: Register indices are word indices on the plain register port.
package dtp_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int DUTY_W = 10;
	localparam int NUM_CH = 3;
	localparam int PHASE_W = 2;

	// ----------------------------------------------------------------
	// Timing: one instruction cycle is four oscillator periods
	// ----------------------------------------------------------------
	localparam int OSC_PERIOD_NS = 10;
	localparam int INSTR_PERIOD_NS = 4 * OSC_PERIOD_NS;
	localparam int INSTR_CYCLES = INSTR_PERIOD_NS / OSC_PERIOD_NS;
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(INSTR_CYCLES - 1);

	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_FLAGS = 4'h1;
	localparam logic [ADDR_W-1:0] REG_TIMER_ONE = 4'h2;
	localparam logic [ADDR_W-1:0] REG_TIMER_TWO = 4'h3;
	localparam logic [ADDR_W-1:0] REG_PERIOD_ONE = 4'h4;
	localparam logic [ADDR_W-1:0] REG_PERIOD_TWO = 4'h5;
	// Duty high of channel n at base + 2n, duty low at base + 2n + 1
	localparam logic [ADDR_W-1:0] REG_DUTY_BASE = 4'h6;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_RUN1 = 0;
	localparam int CTRL_RUN2 = 1;
	localparam int CTRL_CS1 = 2;
	localparam int CTRL_CS2 = 3;
	localparam int CTRL_WIDE = 4;
	localparam int CTRL_EN_LSB = 5;
	localparam int FLAG_T1 = 0;
	localparam int FLAG_T2 = 1;
	localparam int DUTY_LOW_LSB = 6;
	localparam int TB_SEL_BIT = 5;

	// ----------------------------------------------------------------
	// Reset values and timer maximum
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam logic [DATA_W-1:0] TIMER_RST = 8'h00;
	localparam logic [DATA_W-1:0] PERIOD_RST = 8'h00;
	localparam logic [DUTY_W-1:0] DUTY_RST = 10'h000;
	localparam logic [DATA_W-1:0] TIMER_MAX = 8'hff;

endpackage : dtp_pkg

// [dtp_timer.sv]
// Purpose: One 8-bit period timer with software load.
// Assumes: inc is a one-cycle advance pulse, wrap says the count has hit its period.
// Notes: A software load wins over an advance in the same cycle.
`timescale 1ns/1ps
module dtp_timer (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic inc,
	input wire logic wrap,
	input wire logic load,
	input wire logic [dtp_pkg::DATA_W-1:0] load_data,
	output logic [dtp_pkg::DATA_W-1:0] count_q
);

	// Count up, fold to zero on the advance after a period match
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_q <= dtp_pkg::TIMER_RST;
		end else if (load) begin
			count_q <= load_data;
		end else if (inc) begin
			count_q <= wrap ? dtp_pkg::TIMER_RST : count_q + 8'h01;
		end
	end

endmodule : dtp_timer

// [dtp_channel.sv]
// Purpose: One modulator channel: slave duty latch and output compare.
// Assumes: period_start pulses on the advance that folds the timebase to zero.
// Notes: Compare uses the timer count extended by the Q-phase counter.
`timescale 1ns/1ps
module dtp_channel (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic period_start,
	input wire logic [dtp_pkg::DATA_W-1:0] timer_count,
	input wire logic [dtp_pkg::PHASE_W-1:0] phase,
	input wire logic [dtp_pkg::DUTY_W-1:0] master_duty,
	output logic [dtp_pkg::DUTY_W-1:0] slave_duty_q,
	output logic pwm_q
);

	logic [dtp_pkg::DUTY_W-1:0] ext_count;
	logic [dtp_pkg::DUTY_W:0] ext_next;

	// Position inside the period at oscillator resolution
	assign ext_count = {timer_count, phase};
	assign ext_next = {1'b0, ext_count} + 11'h001;

	// Slave latch only moves at a period boundary
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			slave_duty_q <= dtp_pkg::DUTY_RST;
		end else if (period_start) begin
			slave_duty_q <= master_duty;
		end
	end

	// High from period start for duty oscillator periods
	// Looking one count ahead keeps the high time exact to the cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pwm_q <= 1'b0;
		end else if (!enable) begin
			pwm_q <= 1'b0;
		end else if (period_start) begin
			pwm_q <= (master_duty != dtp_pkg::DUTY_RST);
		end else if (ext_next >= {1'b0, slave_duty_q}) begin
			pwm_q <= 1'b0;
		end
	end

endmodule : dtp_channel

// [dtp_pwm_assertions.sv]
// Purpose: Port checks for the pulse-width modulator.
// Assumes: Control and flag writes are shadowed from the register port.
// Notes: Bound to dtp_pwm at the foot of this file.
`timescale 1ns/1ps
module dtp_pwm_assertions (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [dtp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dtp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [dtp_pkg::DATA_W-1:0] reg_rdata_q,
	input wire logic ext_timer_clock_pin,
	input wire logic channel_one,
	input wire logic channel_two,
	input wire logic channel_three,
	input wire logic timer1_flag,
	input wire logic timer2_flag
);
	// ----
	// Shadows
	// ----
	logic [7:0] ctrl_q;
	logic [1:0] clr_q;
	// Control copy; the design register is not visible here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= 8'h00;
		end else if (reg_wr && reg_addr == dtp_pkg::REG_CTRL) begin
			ctrl_q <= reg_wdata;
		end
	end
	// Flag clear strobe, delayed so it lines up with the fall
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			clr_q <= 2'h0;
		end else begin
			clr_q <= (reg_wr && reg_addr == dtp_pkg::REG_FLAGS) ? reg_wdata[1:0] : 2'h0;
		end
	end
	default clocking dcb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// ----
	// Checks
	// ----
	AST_RST_QUIET: assert property ($fell(rst) |->
		!(channel_one || channel_two || channel_three || timer1_flag || timer2_flag))
		else $error("outputs not clear after reset");
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
		else $error("read data outside answer cycle");
	AST_RD_UNMAPPED: assert property (reg_rd && reg_addr > 4'hb |=> reg_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	AST_T1_SW_CLEAR: assert property ($fell(timer1_flag) |-> clr_q[0])
		else $error("timer one flag cleared by hardware");
	AST_T2_SW_CLEAR: assert property ($fell(timer2_flag) |-> clr_q[1])
		else $error("timer two flag cleared by hardware");
	// Run bit as the design saw it at the edge that set the flag
	AST_T1_STOPPED: assert property (!$past(ctrl_q[dtp_pkg::CTRL_RUN1]) |->
		!$rose(timer1_flag))
		else $error("stopped timer one raised flag");
	AST_T2_STOPPED: assert property (!$past(ctrl_q[dtp_pkg::CTRL_RUN2]) |->
		!$rose(timer2_flag))
		else $error("stopped timer two raised flag");
	AST_CH1_AT_ROLL: assert property ($rose(channel_one) |-> timer1_flag)
		else $error("channel one rose off a rollover");
	AST_CH2_AT_ROLL: assert property ($rose(channel_two) |-> timer1_flag || timer2_flag)
		else $error("channel two rose off a rollover");
	AST_CH1_OFF: assert property (!ctrl_q[dtp_pkg::CTRL_EN_LSB] |=> !channel_one)
		else $error("disabled channel one driven");
	AST_PERIOD_GAP: assert property ($rose(channel_one) |=> (!$rose(channel_one)) [*3])
		else $error("channel one period under four cycles");
	// Main scenarios reached
	cover property ($rose(channel_one));
	cover property ($rose(channel_three));
	cover property ($fell(timer1_flag));
endmodule : dtp_pwm_assertions

bind dtp_pwm dtp_pwm_assertions u_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.ext_timer_clock_pin(ext_timer_clock_pin), .channel_one(channel_one),
	.channel_two(channel_two), .channel_three(channel_three),
	.timer1_flag(timer1_flag), .timer2_flag(timer2_flag));

// [dtp_pulse_meter.sv]
// Purpose: Load on one pulse output that tallies high cycles and rises.
// Assumes: Pulse changes only on clock edges.
// Notes: Totals wrap at 16 bits; bench compares differences only.
`timescale 1ns/1ps
module dtp_pulse_meter (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic pulse,
	output logic [15:0] hi_acc,
	output logic [15:0] rises
);
	logic pulse_q;
	// Running totals, so any window of whole periods can be judged
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hi_acc <= 16'h0000;
			rises <= 16'h0000;
			pulse_q <= 1'b0;
		end else begin
			hi_acc <= hi_acc + 16'(pulse);
			rises <= rises + 16'(pulse && !pulse_q);
			pulse_q <= pulse;
		end
	end
endmodule : dtp_pulse_meter

// [test_dtp_pwm.sv]
// Purpose: Self-checking bench for the pulse-width modulator.
// Assumes: Register port with one-cycle strobes, 100 MHz clock.
// Notes: Duty is judged over windows of whole periods.
`timescale 1ns/1ps
module test_dtp_pwm;
	localparam logic [3:0] DB = dtp_pkg::REG_DUTY_BASE;
	logic sys_clk, rst, reg_wr, reg_rd, pin;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_q;
	logic channel_one, channel_two, channel_three, timer1_flag, timer2_flag;
	logic [15:0] hi [3];
	logic [15:0] ri [3];
	logic [15:0] h0 [3];
	logic [15:0] r0 [3];
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	dtp_pwm uut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.ext_timer_clock_pin(pin), .channel_one(channel_one), .channel_two(channel_two),
		.channel_three(channel_three), .timer1_flag(timer1_flag), .timer2_flag(timer2_flag));
	dtp_pulse_meter u_m1 (.sys_clk(sys_clk), .rst(rst), .pulse(channel_one), .hi_acc(hi[0]), .rises(ri[0]));
	dtp_pulse_meter u_m2 (.sys_clk(sys_clk), .rst(rst), .pulse(channel_two), .hi_acc(hi[1]), .rises(ri[1]));
	dtp_pulse_meter u_m3 (.sys_clk(sys_clk), .rst(rst), .pulse(channel_three), .hi_acc(hi[2]), .rises(ri[2]));

	// ----
	// Helpers
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Hang guard, far above the planned run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe edge
	task automatic rchk(input string what, input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(what, 16'(reg_rdata_q), 16'(e));
	endtask : rchk
	task automatic mchk(input int k, input logic [15:0] eh, input logic [15:0] er);
		chk("high cycles", hi[k] - h0[k], eh);
		chk("rises", ri[k] - r0[k], er);
	endtask : mchk

	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		chk("outputs", 16'({channel_one, channel_two, channel_three, timer1_flag, timer2_flag}), 16'h0);
		rchk("ctrl", dtp_pkg::REG_CTRL, 8'h00);
		rchk("timer one", dtp_pkg::REG_TIMER_ONE, 8'h00);
		for (int i = 0; i < 6; i++) begin
			rchk("duty", DB + 4'(i), 8'h00);
		end
		rchk("unmapped", 4'hf, 8'h00);
	endtask : t_reset
	task automatic t_ch1();
		wr(dtp_pkg::REG_PERIOD_ONE, 8'h01);
		wr(DB, 8'h01);
		wr(DB + 4'h1, 8'h40);
		rchk("duty before transfer", DB, 8'h00);
		wr(dtp_pkg::REG_CTRL, 8'h21);
		repeat (20) @(posedge sys_clk);
		rchk("duty high active", DB, 8'h01);
		rchk("duty low active", DB + 4'h1, 8'h40);
		@(negedge sys_clk);
		h0 = hi;
		r0 = ri;
		repeat (32) @(negedge sys_clk);
		mchk(0, 16'd20, 16'd4);
		wr(dtp_pkg::REG_CTRL, 8'h20);
		repeat (20) @(posedge sys_clk);
		chk("flag kept", 16'(timer1_flag), 16'h1);
		wr(dtp_pkg::REG_FLAGS, 8'h03);
		repeat (40) @(posedge sys_clk);
		chk("flag cleared", 16'(timer1_flag), 16'h0);
	endtask : t_ch1
	// Channel one walks the duty corner cases; two and three split timebases
	task automatic t_mix();
		logic [31:0] tc [5] = '{32'h00000000, 32'h01e00701, 32'h03800e01, 32'h03000c01,
			32'h04001000};
		wr(dtp_pkg::REG_PERIOD_ONE, 8'h03);
		wr(dtp_pkg::REG_PERIOD_TWO, 8'h00);
		wr(DB + 4'h3, 8'ha0);
		wr(DB + 4'h5, 8'h80);
		// Wide bit set too: running channels must keep the timers apart
		wr(dtp_pkg::REG_CTRL, 8'hf3);
		for (int i = 0; i < 5; i++) begin
			wr(DB, tc[i][31:24]);
			wr(DB + 4'h1, tc[i][23:16]);
			repeat (40) @(negedge sys_clk);
			h0 = hi;
			r0 = ri;
			repeat (64) @(negedge sys_clk);
			mchk(0, 16'(4 * tc[i][15:8]), 16'(4 * tc[i][7:0]));
			mchk(1, 16'd32, 16'd16);
			mchk(2, 16'd8, 16'd4);
		end
		chk("flag two set", 16'(timer2_flag), 16'h1);
		rchk("ch2 low", DB + 4'h3, 8'ha0);
		wr(dtp_pkg::REG_CTRL, 8'h00);
		wr(dtp_pkg::REG_FLAGS, 8'h02);
		@(negedge sys_clk);
		chk("flag two cleared", 16'(timer2_flag), 16'h0);
		chk("flag one kept", 16'(timer1_flag), 16'h1);
	endtask : t_mix
	task automatic t_ext();
		wr(dtp_pkg::REG_PERIOD_ONE, 8'hff);
		wr(dtp_pkg::REG_TIMER_ONE, 8'h00);
		wr(dtp_pkg::REG_CTRL, 8'h05);
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			pin <= 1'b0;
			rchk("timer behind pin", dtp_pkg::REG_TIMER_ONE, 8'(i));
			repeat (8) @(posedge sys_clk);
			pin <= 1'b1;
			repeat (8) @(posedge sys_clk);
		end
		rchk("external count", dtp_pkg::REG_TIMER_ONE, 8'h05);
	endtask : t_ext
	// Wide mode joins the timers only while every channel is off
	task automatic t_wide();
		wr(dtp_pkg::REG_PERIOD_ONE, 8'h00);
		wr(dtp_pkg::REG_PERIOD_TWO, 8'h05);
		wr(dtp_pkg::REG_TIMER_ONE, 8'hff);
		wr(dtp_pkg::REG_TIMER_TWO, 8'h00);
		// Eight run edges hold exactly two instruction ticks
		wr(dtp_pkg::REG_CTRL, 8'h11);
		repeat (6) @(posedge sys_clk);
		wr(dtp_pkg::REG_CTRL, 8'h10);
		rchk("wide low byte", dtp_pkg::REG_TIMER_ONE, 8'h01);
		rchk("wide carry", dtp_pkg::REG_TIMER_TWO, 8'h01);
	endtask : t_wide

	// ----
	// Main sequence
	// ----
	initial begin
		rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pin = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_ch1();
		t_mix();
		t_ext();
		t_wide();
		report_and_stop();
	end
endmodule : test_dtp_pwm
